// file: logic/cs_region_decode.sv
// Chip-select region decoder: four match/mask regions, a configuration
// port into a 4KB window, and integration-test sideband control.
// Assumes single clock, synchronous inputs, cs_decode_pkg compiled first.
// Function
// - Security attribute of any access is ignored for all decisions.
// - No access is aborted; data and strobes pass unaltered.
// - Four chip selects, one programmable region each.
// - Full 32-bit memory address is accepted; only bits 31:24 are decoded.
// - Each region register holds a match field and a mask field.
// - Region registers accessible only in config or low-power state.
// - Address matching no region goes to chip select 0.
// - Registers occupy a 4KB window at fixed offsets.
// - Reset loads each region register with FF00 (match FF, mask 00); other register bits clear to zero.
// - Integration-test control drives and samples sideband signals.
`include "cs_decode_params.svh"
`timescale 1ns/100ps
`default_nettype none

module cs_region_decode (
    input  wire logic                          sys_clk_i,
    input  wire logic                          sys_rst_i,
    input  wire logic                          mem_valid_i,
    input  wire cs_decode_pkg::mem_req_t       mem_req_i,
    output var  logic                          dec_valid_o,
    output var  cs_decode_pkg::dec_req_t       dec_req_o,
    input  wire cs_decode_pkg::ctrl_state_t    ctrl_state_i,
    input  wire logic                          cfg_wr_i,
    input  wire logic                          cfg_rd_i,
    input  wire logic [`CSD_CFG_ADDR_W-1:0]    cfg_addr_i,
    input  wire logic [`CSD_CFG_DATA_W-1:0]    cfg_wdata_i,
    output var  logic [`CSD_CFG_DATA_W-1:0]    cfg_rdata_o,
    output var  logic                          cfg_ack_o,
    output var  logic                          cfg_refused_o,
    input  wire logic                          itest_en_i,
    input  wire logic [`CSD_SIDE_W-1:0]        itest_drive_i,
    input  wire logic [`CSD_SIDE_W-1:0]        side_in_i,
    output var  logic [`CSD_SIDE_W-1:0]        side_out_o,
    output var  logic [`CSD_SIDE_W-1:0]        itest_sample_o
);
    import cs_decode_pkg::*;

    logic [`CSD_CFG_DATA_W-1:0] region_r [`CSD_NUM_CHIPS];
    logic [`CSD_NUM_CHIPS-1:0]  hit;
    logic [`CSD_NUM_CHIPS-1:0]  sel_wr;
    logic [`CSD_NUM_CHIPS-1:0]  sel_rd;

    // Region window decode inside the 4KB register space
    wire                        cfg_access  = cfg_wr_i | cfg_rd_i;
    wire                        state_open  = (ctrl_state_i == CTRL_CONFIG) ||
                                              (ctrl_state_i == CTRL_LOW_POWER);
    wire                        in_region   = (cfg_addr_i >= `CSD_CHIP_CFG_BASE) &&
                                              (cfg_addr_i <= `CSD_CHIP_CFG_LAST) &&
                                              (cfg_addr_i[1:0] == 2'h0);
    wire [`CSD_CS_W-1:0]        cfg_idx     = cfg_addr_i[3:2];
    wire                        cfg_refuse  = cfg_access & in_region & ~state_open;
    wire                        cfg_write   = cfg_wr_i & in_region & state_open;
    wire                        cfg_read    = cfg_rd_i & in_region & state_open;
    wire [`CSD_ADDR_CMP_MSB-`CSD_ADDR_CMP_LSB:0] addr_cmp =
                                              mem_req_i.addr[`CSD_ADDR_CMP_MSB:`CSD_ADDR_CMP_LSB];

    genvar g;
    generate
        for (g = 0; g < `CSD_NUM_CHIPS; g++) begin : g_region
            wire [7:0] match_f = region_r[g][`CSD_MATCH_MSB:`CSD_MATCH_LSB];
            wire [7:0] mask_f  = region_r[g][`CSD_MASK_MSB:`CSD_MASK_LSB];
            assign hit[g]    = ((addr_cmp & mask_f) == (match_f & mask_f));
            assign sel_wr[g] = cfg_write & (cfg_idx == `CSD_CS_W'(g));
            assign sel_rd[g] = cfg_read & (cfg_idx == `CSD_CS_W'(g));
            always_ff @(posedge sys_clk_i) begin
                if (sys_rst_i) begin
                    region_r[g] <= `CSD_CHIP_CFG_RST;
                end else if (sel_wr[g]) begin
                    region_r[g] <= cfg_wdata_i;
                end
            end
        end
    endgenerate

    // Lowest-numbered hit wins; overlap is not guarded against in hardware
    wire                 any_hit = |hit;
    wire [`CSD_CS_W-1:0] hit_cs  = hit[0] ? 2'h0 :
                                   hit[1] ? 2'h1 :
                                   hit[2] ? 2'h2 : 2'h3;
    wire [`CSD_CS_W-1:0] cs_nxt  = any_hit ? hit_cs : `CSD_DEFAULT_CS;

    // Security bit is deliberately unused: data and strobes pass untouched
    dec_req_t dec_nxt;
    assign dec_nxt.addr  = mem_req_i.addr;
    assign dec_nxt.write = mem_req_i.write;
    assign dec_nxt.wstrb = mem_req_i.wstrb;
    assign dec_nxt.cs    = cs_nxt;
    assign dec_nxt.miss  = ~any_hit;

    wire [`CSD_CFG_DATA_W-1:0] rdata_nxt = (|sel_rd) ? region_r[cfg_idx] : 16'h0000;
    wire [`CSD_SIDE_W-1:0]     cs_onehot = dec_valid_o ? (4'h1 << dec_req_o.cs) : 4'h0;
    wire [`CSD_SIDE_W-1:0]     side_nxt  = itest_en_i ? itest_drive_i : cs_onehot;

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            dec_valid_o <= 1'b0;
            dec_req_o   <= '0;
        end else begin
            dec_valid_o <= mem_valid_i;
            dec_req_o   <= dec_nxt;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            cfg_rdata_o   <= 16'h0000;
            cfg_ack_o     <= 1'b0;
            cfg_refused_o <= 1'b0;
        end else begin
            cfg_rdata_o   <= rdata_nxt;
            cfg_ack_o     <= cfg_access;
            cfg_refused_o <= cfg_refuse;
        end
    end

    // Sampling is registered so the bench sees sideband inputs one edge late
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            side_out_o     <= 4'h0;
            itest_sample_o <= 4'h0;
        end else begin
            side_out_o     <= side_nxt;
            itest_sample_o <= side_in_i;
        end
    end

endmodule

`default_nettype wire

// file: shared/cs_decode_params.svh
// Constants for the chip-select region decoder: offsets, field positions,
// reset values and widths. Definitions only; included by the package and logic.
`ifndef CS_DECODE_PARAMS_SVH
`define CS_DECODE_PARAMS_SVH

`define CSD_NUM_CHIPS        4
`define CSD_CS_W             2
`define CSD_ADDR_W           32
`define CSD_STRB_W           4
`define CSD_CFG_ADDR_W       12
`define CSD_CFG_DATA_W       16
`define CSD_SIDE_W           4

`define CSD_CHIP_CFG_BASE    12'h200
`define CSD_CHIP_CFG_STRIDE  12'h004
`define CSD_CHIP_CFG_LAST    12'h20C

`define CSD_MATCH_MSB        15
`define CSD_MATCH_LSB        8
`define CSD_MASK_MSB         7
`define CSD_MASK_LSB         0
`define CSD_ADDR_CMP_MSB     31
`define CSD_ADDR_CMP_LSB     24

`define CSD_CHIP_CFG_RST     16'hFF00
`define CSD_DEFAULT_CS       2'h0

`endif

// file: shared/cs_decode_pkg.sv
// Types shared by the chip-select region decoder and its bench.
// Assumes cs_decode_params.svh is on the include path.
`include "cs_decode_params.svh"

package cs_decode_pkg;

    typedef enum logic [2:0] {
        CTRL_CONFIG,
        CTRL_LOW_POWER,
        CTRL_READY,
        CTRL_PAUSED,
        CTRL_OTHER
    } ctrl_state_t;

    typedef struct packed {
        logic [`CSD_ADDR_W-1:0] addr;
        logic                   write;
        logic [`CSD_STRB_W-1:0] wstrb;
        logic                   secure;
    } mem_req_t;

    typedef struct packed {
        logic [`CSD_ADDR_W-1:0] addr;
        logic                   write;
        logic [`CSD_STRB_W-1:0] wstrb;
        logic [`CSD_CS_W-1:0]   cs;
        logic                   miss;
    } dec_req_t;

endpackage

// file: verif/csd_props.sv
// Port checker for the region decoder.
// Assumes cs_decode_pkg is compiled first.
`timescale 1ns/100ps
`default_nettype none
module csd_props (
    input wire logic                    sys_clk_i,
    input wire logic                    sys_rst_i,
    input wire logic                    mem_valid_i,
    input wire cs_decode_pkg::mem_req_t mem_req_i,
    input wire logic                    dec_valid_o,
    input wire cs_decode_pkg::dec_req_t dec_req_o,
    input wire logic                    cfg_wr_i,
    input wire logic                    cfg_rd_i,
    input wire logic                    cfg_ack_o,
    input wire logic                    cfg_refused_o,
    input wire logic [15:0]             cfg_rdata_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    chk_valid_kept: assert property (mem_valid_i |=> dec_valid_o) else $error("lost");
    chk_no_phantom: assert property (!mem_valid_i |=> !dec_valid_o) else $error("phantom");
    chk_addr_whole: assert property (mem_valid_i |=> dec_req_o.addr == $past(mem_req_i.addr)) else $error("addr");
    chk_strb_kept: assert property (mem_valid_i |=> dec_req_o.wstrb == $past(mem_req_i.wstrb)) else $error("strb");
    chk_miss_zero: assert property (dec_valid_o && dec_req_o.miss |-> dec_req_o.cs == 2'h0) else $error("miss");
    chk_cfg_ack: assert property (cfg_wr_i || cfg_rd_i |=> cfg_ack_o) else $error("ack");
    chk_ack_cause: assert property (!cfg_wr_i && !cfg_rd_i |=> !cfg_ack_o) else $error("stray");
    chk_refused_quiet: assert property (cfg_refused_o |-> cfg_ack_o && cfg_rdata_o == 16'h0000) else $error("ref");
endmodule
bind cs_region_decode csd_props u_props (.sys_clk_i, .sys_rst_i, .mem_valid_i, .mem_req_i,
    .dec_valid_o, .dec_req_o, .cfg_wr_i, .cfg_rd_i, .cfg_ack_o, .cfg_refused_o, .cfg_rdata_o);
`default_nettype wire

// file: verif/far_mem.sv
// Memory-side stub: counts decoded requests.
// Its count moves the sideband inputs every request.
`timescale 1ns/100ps
`default_nettype none
module far_mem (
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       valid_i,
    output var logic [3:0] side_o
);
    always_ff @(posedge clk_i) side_o <= rst_i ? 4'h0 : side_o + 4'(valid_i);
endmodule
`default_nettype wire

// file: verif/cs_region_decode_test.sv
// Bench for the region decoder: config port and decode.
// Assumes package, checker and stub compiled first.
`timescale 1ns/100ps
`default_nettype none
module cs_region_decode_test;
    import cs_decode_pkg::*;
    logic        clk = 0, rst = 1, mv = 0, wr = 0, rd = 0, dv, ack, rf;
    mem_req_t    req = '0;
    dec_req_t    dr;
    ctrl_state_t st = CTRL_CONFIG;
    logic [11:0] ca = '0;
    logic [15:0] cw = '0, rdat;
    logic [3:0]  side, sout, samp, idrv = '0;
    logic        ie = 0;
    int          failures = 0, num_checks = 0, cyc = 0;
    cs_region_decode uut (.sys_clk_i(clk), .sys_rst_i(rst), .mem_valid_i(mv), .mem_req_i(req), .dec_valid_o(dv),
        .dec_req_o(dr), .ctrl_state_i(st), .cfg_wr_i(wr), .cfg_rd_i(rd), .cfg_addr_i(ca), .cfg_wdata_i(cw),
        .cfg_rdata_o(rdat), .cfg_ack_o(ack), .cfg_refused_o(rf), .itest_en_i(ie), .itest_drive_i(idrv),
        .side_in_i(side), .side_out_o(sout), .itest_sample_o(samp));
    far_mem fm (.clk_i(clk), .rst_i(rst), .valid_i(dv), .side_o(side));
    initial forever #50 clk = ~clk;
    always @(posedge clk) if (++cyc == 3000) begin
        failures++;
        conclude;
    end
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic conclude;
        $display("checks=%0d failures=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Strobe held one cycle; answer judged just after the taking edge
    task automatic cfg(input logic w, input logic [11:0] a, input logic [15:0] d, input logic [15:0] er,
                       input logic ef, input ctrl_state_t s);
        @(posedge clk);
        wr <= w;
        rd <= !w;
        ca <= a;
        cw <= d;
        st <= s;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        #1;
        check(ack, 1'b1);
        check(rdat, er);
        check(rf, ef);
    endtask
    task automatic send(input logic [31:0] a, input logic s, input logic [1:0] ecs, input logic em);
        @(posedge clk);
        mv <= 1'b1;
        req <= '{a, 1'b1, 4'h5, s};
        @(posedge clk);
        mv <= 1'b0;
        #1;
        check(dv, 1'b1);
        check(dr.wstrb, 4'h5);
        check({dr.cs, dr.miss}, {ecs, em});
    endtask
    task automatic t_regions;
        cfg(0, 12'h200, 0, 16'hFF00, 0, CTRL_CONFIG);
        for (int n = 0; n < 4; n++) cfg(1, 12'h200 + 12'(4 * n), {8'(16 * n + 16), 8'hF0}, 0, 0, CTRL_CONFIG);
        for (int n = 0; n < 4; n++) send({8'(17 * n + 16), 24'h00ABCD}, n[0], 2'(n), 0);
        send(32'hFFFFFFFC, 1, 2'h0, 1);
        cfg(1, 12'h20C, 16'h10F0, 0, 0, CTRL_LOW_POWER);
        send(32'h1F000000, 0, 2'h0, 0);
    endtask
    task automatic t_states;
        cfg(1, 12'h204, 16'hAAFF, 0, 1, CTRL_READY);
        cfg(0, 12'h204, 0, 0, 1, CTRL_PAUSED);
        cfg(0, 12'h204, 0, 16'h20F0, 0, CTRL_LOW_POWER);
        cfg(1, 12'h100, 16'h1234, 0, 0, CTRL_CONFIG);
        cfg(0, 12'h202, 0, 0, 0, CTRL_CONFIG);
    endtask
    // Seventh request overall; stub count reaches the sample port two edges on
    task automatic t_itest;
        send(32'h32000000, 0, 2'h2, 0);
        @(posedge clk);
        #1;
        check(sout, 4'h4);
        @(posedge clk);
        #1;
        check(samp, 4'h7);
        @(posedge clk);
        ie <= 1'b1;
        idrv <= 4'hA;
        @(posedge clk);
        ie <= 1'b0;
        #1;
        check(sout, 4'hA);
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_regions;
        t_states;
        t_itest;
        conclude;
    end
endmodule
`default_nettype wire
